// ### dcp_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_far_side #(
  parameter int PERIOD = 64
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 timer_run,
  input  wire logic                 shared_timer_clear,
  output var  logic [15:0]          shared_timer,
  output var  dcp_pkg::dcp_period_t period_base
);
  logic [15:0] timer_reg;
  logic [9:0]  period_count_reg;

  // Timer may be stopped, so capture values can be known exactly
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_reg <= 16'h0000;
    else if (shared_timer_clear)
      timer_reg <= 16'h0000;
    else if (timer_run)
      timer_reg <= timer_reg + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      period_count_reg <= 10'h000;
    else if (period_count_reg == 10'(PERIOD - 1))
      period_count_reg <= 10'h000;
    else
      period_count_reg <= period_count_reg + 10'h001;
  end

  always_comb
  begin
    shared_timer = timer_reg;
    period_base.count = period_count_reg;
    period_base.period_event = (period_count_reg == 10'h000);
  end
endmodule : dcp_far_side
`default_nettype wire

// ### dcp_params.svh
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH

`define DCP_OFS_CTRL0   4'h0
`define DCP_OFS_CTRL1   4'h1
`define DCP_OFS_VAL0_LO 4'h2
`define DCP_OFS_VAL0_HI 4'h3
`define DCP_OFS_VAL1_LO 4'h4
`define DCP_OFS_VAL1_HI 4'h5
`define DCP_OFS_STATUS  4'h6
`define DCP_OFS_MASK    4'h7

`define DCP_DUTY_MSB 5
`define DCP_DUTY_LSB 4
`define DCP_MODE_MSB 3

`define DCP_CTRL_RST 6'h00
`define DCP_VAL_RST  16'h0000
`define DCP_DUTY_RST 10'h000
`define DCP_IRQ_RST  2'h0
`define DCP_PRE_RST  4'h0

`define DCP_MODE_CMP_TOG   4'h2
`define DCP_MODE_CAP_FALL  4'h4
`define DCP_MODE_CAP_RISE  4'h5
`define DCP_MODE_CAP_4TH   4'h6
`define DCP_MODE_CAP_16TH  4'h7
`define DCP_MODE_CMP_SET   4'h8
`define DCP_MODE_CMP_CLR   4'h9
`define DCP_MODE_CMP_SWI   4'ha
`define DCP_MODE_CMP_SPEC  4'hb

`define DCP_PRE_4TH  4'h3
`define DCP_PRE_16TH 4'hf

`endif

// ### dcp_pkg.sv
`default_nettype none
package dcp_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dcp_bus_req_t;

  // Pulse time base: ten-bit period count (a counter of its own, apart from the shared timer) and period event
  typedef struct packed {
    logic [9:0] count;
    logic       period_event;
  } dcp_period_t;

  typedef enum logic [3:0] {
    DCP_OFF     = 4'b0001,
    DCP_CAPTURE = 4'b0010,
    DCP_COMPARE = 4'b0100,
    DCP_PWM     = 4'b1000
  } dcp_kind_t;

  function automatic dcp_kind_t dcp_kind(input logic [3:0] mode);
    dcp_kind_t k;
    k = DCP_OFF;
    case (mode[3:2])
      2'b00:   k = (mode == 4'h2) ? DCP_COMPARE : DCP_OFF;
      2'b01:   k = DCP_CAPTURE;
      2'b10:   k = DCP_COMPARE;
      default: k = DCP_PWM;
    endcase
    return k;
  endfunction : dcp_kind

endpackage : dcp_pkg
`default_nettype wire

// ### dcp_unit_pair.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcp_params.svh"

module dcp_unit_pair #(
  parameter int UNITS = 2
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire dcp_pkg::dcp_bus_req_t bus_req,
  output var  logic [7:0]            rd_data,
  input  wire logic [15:0]           shared_timer,
  input  wire dcp_pkg::dcp_period_t  period_base,
  output var  logic                  shared_timer_clear,
  output var  logic                  conversion_trigger,
  input  wire logic [UNITS-1:0]      unit_pin_in,
  output wire logic [UNITS-1:0]      unit_pin_out,
  output wire logic [UNITS-1:0]      unit_pin_oe,
  output wire logic                  irq
);

  logic [UNITS-1:0][5:0]  ctrl_w;
  logic [UNITS-1:0][15:0] val_w;
  logic [UNITS-1:0][9:0]  duty_w;
  logic [UNITS-1:0][3:0]  pre_w;
  logic [UNITS-1:0]       cap_w;
  logic [UNITS-1:0]       match_w;
  logic [UNITS-1:0]       evt_w;
  logic [UNITS-1:0]       clr_w;
  logic [UNITS-1:0]       pwm_w;
  logic [1:0]             status_reg;
  logic [1:0]             mask_reg;
  logic [7:0]             rd_next;
  logic                   rd_status;

  assign rd_status = bus_req.rd && (bus_req.addr == `DCP_OFS_STATUS);

  genvar i;
  generate
    for (i = 0; i < UNITS; i++)
    begin : g_unit
      localparam logic [3:0] OFS_CTRL = (i == 0) ? `DCP_OFS_CTRL0 : `DCP_OFS_CTRL1;
      localparam logic [3:0] OFS_LO   = (i == 0) ? `DCP_OFS_VAL0_LO : `DCP_OFS_VAL1_LO;
      localparam logic [3:0] OFS_HI   = (i == 0) ? `DCP_OFS_VAL0_HI : `DCP_OFS_VAL1_HI;

      logic [5:0]         ctrl_reg;
      logic [15:0]        val_reg;
      logic [9:0]         duty_reg;
      logic [9:0]         duty_next;
      logic [3:0]         pre_reg;
      logic               sync1_reg;
      logic               sync2_reg;
      logic               prev_reg;
      logic               out_reg;
      logic               match_prev_reg;
      logic               wr_ctrl;
      logic               rise;
      logic               fall;
      logic               edge_hit;
      logic               match_now;
      logic [3:0]         mode;
      dcp_pkg::dcp_kind_t kind;

      assign mode      = ctrl_reg[`DCP_MODE_MSB:0];
      assign kind      = dcp_pkg::dcp_kind(mode);
      assign wr_ctrl   = bus_req.wr && (bus_req.addr == OFS_CTRL);
      assign rise      = sync2_reg && !prev_reg;
      assign fall      = !sync2_reg && prev_reg;
      assign duty_next = {val_reg[7:0], ctrl_reg[`DCP_DUTY_MSB:`DCP_DUTY_LSB]};

      always_comb
      begin
        case (mode)
          `DCP_MODE_CAP_FALL:  edge_hit = fall;
          `DCP_MODE_CAP_RISE:  edge_hit = rise;
          `DCP_MODE_CAP_4TH:   edge_hit = rise && ((pre_reg & `DCP_PRE_4TH) == `DCP_PRE_4TH);
          `DCP_MODE_CAP_16TH:  edge_hit = rise && (pre_reg == `DCP_PRE_16TH);
          default:             edge_hit = 1'b0;
        endcase
      end

      // Capture sees only the shared timer; pulse mode sees only the period base
      assign cap_w[i]   = (kind == dcp_pkg::DCP_CAPTURE) && edge_hit;
      assign match_now  = (kind == dcp_pkg::DCP_COMPARE) && (shared_timer == val_reg);
      // One event per match: the timer may sit on the value for many cycles
      assign match_w[i] = match_now && !match_prev_reg;
      assign evt_w[i]   = cap_w[i] || match_w[i];
      assign clr_w[i]   = match_w[i] && (mode == `DCP_MODE_CMP_SPEC);
      assign pwm_w[i]   = (kind == dcp_pkg::DCP_PWM);
      assign ctrl_w[i]  = ctrl_reg;
      assign val_w[i]   = val_reg;
      assign duty_w[i]  = duty_reg;
      assign pre_w[i]   = pre_reg;
      assign unit_pin_out[i] = out_reg;
      assign unit_pin_oe[i]  = (kind == dcp_pkg::DCP_COMPARE) || (kind == dcp_pkg::DCP_PWM);

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          ctrl_reg <= `DCP_CTRL_RST;
        else if (wr_ctrl)
          ctrl_reg <= bus_req.wdata[5:0];
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
          prev_reg  <= 1'b0;
        end
        else
        begin
          sync1_reg <= unit_pin_in[i];
          sync2_reg <= sync1_reg;
          prev_reg  <= sync2_reg;
        end
      end

      // Prescaler restarts on any control write so a new mode counts from zero
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          pre_reg <= `DCP_PRE_RST;
        else if (wr_ctrl || kind != dcp_pkg::DCP_CAPTURE)
          pre_reg <= `DCP_PRE_RST;
        else if (rise)
          pre_reg <= pre_reg + 4'h1;
      end

      // Hardware capture beats a software write in the same cycle
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          val_reg <= `DCP_VAL_RST;
        else if (cap_w[i])
          val_reg <= shared_timer;
        else if (bus_req.wr && bus_req.addr == OFS_LO)
          val_reg <= {val_reg[15:8], bus_req.wdata};
        else if (bus_req.wr && bus_req.addr == OFS_HI)
          val_reg <= {bus_req.wdata, val_reg[7:0]};
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          match_prev_reg <= 1'b0;
        else
          match_prev_reg <= match_now;
      end

      // Duty is double-buffered so both units switch on the same period event
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          duty_reg <= `DCP_DUTY_RST;
        else if (pwm_w[i] && period_base.period_event)
          duty_reg <= duty_next;
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          out_reg <= 1'b0;
        else
        begin
          case (kind)
            dcp_pkg::DCP_COMPARE:
            begin
              if (match_w[i])
              begin
                if (mode == `DCP_MODE_CMP_SET)
                  out_reg <= 1'b1;
                else if (mode == `DCP_MODE_CMP_CLR)
                  out_reg <= 1'b0;
                else if (mode == `DCP_MODE_CMP_TOG)
                  out_reg <= !out_reg;
              end
            end
            dcp_pkg::DCP_PWM:
            begin
              // Rising edge only at the shared period event keeps units aligned
              if (period_base.period_event)
                out_reg <= (duty_next != `DCP_DUTY_RST);
              else if (period_base.count >= duty_reg)
                out_reg <= 1'b0;
            end
            default:
              out_reg <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shared_timer_clear <= 1'b0;
      conversion_trigger <= 1'b0;
    end
    else
    begin
      shared_timer_clear <= |clr_w;
      conversion_trigger <= clr_w[1];
    end
  end

  // An event in the cycle of the clearing read survives it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= `DCP_IRQ_RST;
    else if (rd_status)
      status_reg <= evt_w;
    else
      status_reg <= status_reg | evt_w;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_reg <= `DCP_IRQ_RST;
    else if (bus_req.wr && bus_req.addr == `DCP_OFS_MASK)
      mask_reg <= bus_req.wdata[1:0];
  end

  assign irq = |(status_reg & mask_reg);

  always_comb
  begin
    rd_next = 8'h00;
    if (!bus_req.rd)
      rd_next = 8'h00;
    else if (bus_req.addr == `DCP_OFS_CTRL0)
      rd_next = {2'h0, ctrl_w[0]};
    else if (bus_req.addr == `DCP_OFS_CTRL1)
      rd_next = {2'h0, ctrl_w[1]};
    else if (bus_req.addr == `DCP_OFS_VAL0_LO)
      rd_next = val_w[0][7:0];
    else if (bus_req.addr == `DCP_OFS_VAL0_HI)
      rd_next = val_w[0][15:8];
    else if (bus_req.addr == `DCP_OFS_VAL1_LO)
      rd_next = val_w[1][7:0];
    else if (bus_req.addr == `DCP_OFS_VAL1_HI)
      rd_next = val_w[1][15:8];
    else if (bus_req.addr == `DCP_OFS_STATUS)
      rd_next = {6'h00, status_reg};
    else if (bus_req.addr == `DCP_OFS_MASK)
      rd_next = {6'h00, mask_reg};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else
      rd_data <= rd_next;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_capture_copy: assert property (
    cap_w[0] |=> val_w[0] == $past(shared_timer))
    else $error("capture did not copy shared timer");

  chk_capture_overwrite: assert property (
    cap_w[0] && status_reg[0] |=> val_w[0] == $past(shared_timer) && status_reg[0])
    else $error("pending capture not overwritten");

  chk_prescale_sixteen: assert property (
    cap_w[1] && ctrl_w[1][3:0] == `DCP_MODE_CAP_16TH |-> pre_w[1] == `DCP_PRE_16TH)
    else $error("sixteenth edge capture at wrong count");

  chk_compare_set: assert property (
    match_w[0] && ctrl_w[0][3:0] == `DCP_MODE_CMP_SET |=> unit_pin_out[0] ##1 status_reg[0])
    else $error("compare set did not drive pin");

  chk_pwm_fall: assert property (
    pwm_w[0] && !period_base.period_event && period_base.count >= duty_w[0]
      |=> !unit_pin_out[0])
    else $error("pulse output high past duty");

  chk_duty_together: assert property (
    (&pwm_w) && period_base.period_event
      |=> duty_w[0] == $past({val_w[0][7:0], ctrl_w[0][5:4]})
       && duty_w[1] == $past({val_w[1][7:0], ctrl_w[1][5:4]}))
    else $error("duty values not loaded together");

  chk_rise_aligned: assert property (
    (&pwm_w) && $past(&pwm_w) && $rose(unit_pin_out[0]) && duty_w[1] != 10'h000
      |-> $rose(unit_pin_out[1]))
    else $error("pulse rising edges not aligned");

  chk_first_clears: assert property (
    match_w[0] && ctrl_w[0][3:0] == `DCP_MODE_CMP_SPEC |=> shared_timer_clear)
    else $error("first unit match did not clear timer");

  chk_second_clears: assert property (
    match_w[1] && ctrl_w[1][3:0] == `DCP_MODE_CMP_SPEC
      |=> shared_timer_clear && conversion_trigger)
    else $error("second unit match did not clear timer");

  chk_ctrl_top_zero: assert property (
    bus_req.rd && bus_req.addr == `DCP_OFS_CTRL1 |=> rd_data[7:6] == 2'h0)
    else $error("control top bits not zero");

  chk_flag_sticky: assert property (
    status_reg[0] && !rd_status |=> status_reg[0])
    else $error("event flag dropped without read");

  chk_flag_sticky_hi: assert property (
    status_reg[1] && !rd_status |=> status_reg[1])
    else $error("second event flag dropped without read");

  chk_capture_copy_hi: assert property (
    cap_w[1] |=> val_w[1] == $past(shared_timer))
    else $error("second capture did not copy shared timer");

  chk_capture_flag: assert property (
    cap_w[1] |=> status_reg[1])
    else $error("capture did not set event flag");

  chk_compare_clear: assert property (
    match_w[1] && ctrl_w[1][3:0] == `DCP_MODE_CMP_CLR |=> !unit_pin_out[1])
    else $error("compare clear did not drive pin low");

  chk_compare_toggle: assert property (
    match_w[1] && ctrl_w[1][3:0] == `DCP_MODE_CMP_TOG
      |=> unit_pin_out[1] != $past(unit_pin_out[1]))
    else $error("compare toggle did not flip pin");

  chk_duty_hold: assert property (
    pwm_w[0] && !period_base.period_event |=> $stable(duty_w[0]))
    else $error("duty changed between period events");

  chk_pwm_rise_event: assert property (
    pwm_w[0] && $past(pwm_w[0]) && $rose(unit_pin_out[0])
      |-> $past(period_base.period_event))
    else $error("pulse output rose off the period event");

endmodule : dcp_unit_pair
`default_nettype wire

// ### dual_capture_compare_pwm_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcp_params.svh"
module dual_capture_compare_pwm_tb;
  logic                  clk;
  logic                  rst_n;
  dcp_pkg::dcp_bus_req_t bus_req;
  logic [7:0]            rd_data;
  logic [15:0]           shared_timer;
  dcp_pkg::dcp_period_t  period_base;
  logic                  shared_timer_clear;
  logic                  conversion_trigger;
  logic [1:0]            pin_drv;
  logic [1:0]            pin_out;
  logic [1:0]            pin_oe;
  logic                  irq;
  logic                  timer_run;
  logic [7:0]            rv;
  int                    n_mismatch;
  int                    tests_run;
  // Block's drive wins while enabled, else the outside source
  wire logic [1:0]       pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_drv);

  dcp_unit_pair dcp_unit_pair_inst (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .rd_data(rd_data), .shared_timer(shared_timer), .period_base(period_base),
    .shared_timer_clear(shared_timer_clear), .conversion_trigger(conversion_trigger),
    .unit_pin_in(pin_wire), .unit_pin_out(pin_out), .unit_pin_oe(pin_oe), .irq(irq));
  dcp_far_side #(.PERIOD(64)) dcp_far_side_inst (.clk(clk), .rst_n(rst_n),
    .timer_run(timer_run), .shared_timer_clear(shared_timer_clear),
    .shared_timer(shared_timer), .period_base(period_base));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic hang();
    n_mismatch++;
    give_verdict();
  endtask : hang

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : bus_wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    rv = rd_data;
    chk(what, rv, exp);
  endtask : rd_chk

  task automatic pulse(input int u);
    @(posedge clk);
    pin_drv[u] <= 1'b1;
    repeat (5) @(posedge clk);
    pin_drv[u] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : pulse

  task automatic t_regs();
    rd_chk(`DCP_OFS_CTRL0, 8'h00, "ctrl0 reset");
    rd_chk(`DCP_OFS_VAL1_HI, 8'h00, "val1 reset");
    bus_wr(`DCP_OFS_CTRL0, 8'hf1);
    rd_chk(`DCP_OFS_CTRL0, 8'h31, "ctrl0 bits");
    rd_chk(`DCP_OFS_CTRL1, 8'h00, "ctrl1 apart");
    bus_wr(4'h9, 8'hff);
    rd_chk(4'h9, 8'h00, "unmapped");
    chk("oe off", pin_oe, 2'b00);
  endtask : t_regs

  task automatic t_cap(input int u, input logic [3:0] mode, input int n);
    logic [15:0] snap;
    timer_run <= 1'b1;
    repeat (3 + n) @(posedge clk);
    timer_run <= 1'b0;
    bus_wr(4'(u), {4'h0, mode});
    snap = shared_timer;
    for (int i = 1; i < n; i++)
      pulse(u);
    if (n > 1)
      rd_chk(`DCP_OFS_STATUS, 8'h00, "early");
    pulse(u);
    rd_chk(`DCP_OFS_VAL0_LO + 4'(2 * u), snap[7:0], "cap lo");
    rd_chk(`DCP_OFS_VAL0_HI + 4'(2 * u), snap[15:8], "cap hi");
    rd_chk(`DCP_OFS_STATUS, 8'(1 << u), "cap flag");
  endtask : t_cap

  task automatic t_over();
    logic [15:0] snap;
    bus_wr(`DCP_OFS_CTRL0, {4'h0, `DCP_MODE_CAP_RISE});
    bus_wr(`DCP_OFS_MASK, 8'h01);
    pulse(0);
    chk("irq on", irq, 1'b1);
    timer_run <= 1'b1;
    repeat (7) @(posedge clk);
    timer_run <= 1'b0;
    repeat (2) @(posedge clk);
    snap = shared_timer;
    pulse(0);
    rd_chk(`DCP_OFS_VAL0_LO, snap[7:0], "newer lo");
    rd_chk(`DCP_OFS_STATUS, 8'h01, "one flag");
    rd_chk(`DCP_OFS_STATUS, 8'h00, "cleared");
    chk("irq off", irq, 1'b0);
    bus_wr(`DCP_OFS_MASK, 8'h00);
    pulse(0);
    chk("irq masked", irq, 1'b0);
    rd_chk(`DCP_OFS_STATUS, 8'h01, "masked flag");
  endtask : t_over

  task automatic t_cmp(input int u, input logic [3:0] mode, input logic exp_pin);
    logic [15:0] v;
    logic        spec;
    int          k;
    spec = (mode == `DCP_MODE_CMP_SPEC);
    timer_run <= 1'b1;
    v = shared_timer + 16'h0020;
    bus_wr(`DCP_OFS_VAL0_LO + 4'(2 * u), v[7:0]);
    bus_wr(`DCP_OFS_VAL0_HI + 4'(2 * u), v[15:8]);
    bus_wr(4'(u), {4'h0, mode});
    for (k = 0; k < 100 && shared_timer !== v + 16'h0001; k++)
      @(negedge clk);
    if (k == 100)
      hang();
    chk("cmp pin", pin_out[u], exp_pin);
    chk("cmp oe", pin_oe[u], 1'b1);
    chk("clear", shared_timer_clear, spec);
    chk("trigger", conversion_trigger, spec && u == 1);
    if (spec)
      bus_wr(4'(u), 8'h00);
    rd_chk(`DCP_OFS_STATUS, 8'(1 << u), "status");
    chk("cmp flag", rv[u], 1'b1);
  endtask : t_cmp

  task automatic t_pwm();
    int k;
    int h0;
    int h1;
    h0 = 0;
    h1 = 0;
    bus_wr(`DCP_OFS_VAL0_LO, 8'h04);
    bus_wr(`DCP_OFS_VAL1_LO, 8'h02);
    bus_wr(`DCP_OFS_CTRL0, 8'h1c);
    bus_wr(`DCP_OFS_CTRL1, 8'h3c);
    repeat (2)
    begin
      @(negedge clk);
      for (k = 0; k < 200 && period_base.period_event !== 1'b1; k++)
        @(negedge clk);
      if (k == 200)
        hang();
    end
    for (k = 0; k < 64; k++)
    begin
      @(negedge clk);
      if (k == 0)
        chk("aligned rise", pin_out, 2'b11);
      h0 += int'(pin_out[0]);
      h1 += int'(pin_out[1]);
    end
    chk("duty0", h0[15:0], 16'h0011);
    chk("duty1", h1[15:0], 16'h000b);
  endtask : t_pwm

  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    pin_drv = 2'b00;
    timer_run = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_cap(0, `DCP_MODE_CAP_FALL, 1);
    t_cap(1, `DCP_MODE_CAP_RISE, 1);
    t_cap(0, `DCP_MODE_CAP_4TH, 4);
    t_cap(1, `DCP_MODE_CAP_16TH, 16);
    t_over();
    t_cmp(1, `DCP_MODE_CMP_SET, 1'b1);
    t_cmp(1, `DCP_MODE_CMP_CLR, 1'b0);
    t_cmp(1, `DCP_MODE_CMP_TOG, 1'b1);
    t_cmp(1, `DCP_MODE_CMP_SWI, 1'b1);
    t_cmp(1, `DCP_MODE_CMP_SPEC, 1'b1);
    t_cmp(0, `DCP_MODE_CMP_SET, 1'b1);
    t_cmp(0, `DCP_MODE_CMP_SPEC, 1'b1);
    t_pwm();
    give_verdict();
  end
endmodule : dual_capture_compare_pwm_tb
`default_nettype wire
